//--- logic/flag_consts.svh
`ifndef FLAG_CONSTS_SVH
`define FLAG_CONSTS_SVH

// ****************************************
// Time base
// ****************************************
`define CLK_PERIOD_NS 10
`define NS_PER_MS 1000000
`define MS_PER_SEC 1000

// ****************************************
// Pulse flag half periods
// ****************************************
`define FAST_HALF_MS 5
`define TENTH_HALF_MS 50
`define SECOND_HALF_MS 500
`define MINUTE_HALF_SEC 30

// ****************************************
// Widths and reset values
// ****************************************
`define HALF_CNT_W 15
`define SCAN_TIME_W 16
`define PRESCALE_W 17
`define RTC_FAULT_RST 1'b0
`define OUTPUTS_OFF_RST 1'b0

`endif

//--- logic/flag_pkg.sv
package flag_pkg;

  typedef enum logic [0:0] {
    SCAN_BUSY,
    SCAN_HOLD
  } scan_state_type;

endpackage

//--- logic/pulse_time_base.sv
`timescale 1ns/1ps
`include "flag_consts.svh"

module pulse_time_base
  import flag_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `NS_PER_MS / `CLK_PERIOD_NS
)
(
  input wire logic core_clk,
  input wire logic srst,
  output logic ms_tick,
  output logic flag_10ms,
  output logic flag_100ms,
  output logic flag_1s,
  output logic flag_1min
);

  localparam logic [`PRESCALE_W-1:0] PRE_LAST = `PRESCALE_W'(MS_CYCLES - 1);
  localparam logic [`HALF_CNT_W-1:0] FAST_LAST = `HALF_CNT_W'(`FAST_HALF_MS - 1);
  localparam logic [`HALF_CNT_W-1:0] TENTH_LAST = `HALF_CNT_W'(`TENTH_HALF_MS - 1);
  localparam logic [`HALF_CNT_W-1:0] SECOND_LAST = `HALF_CNT_W'(`SECOND_HALF_MS - 1);
  localparam logic [`HALF_CNT_W-1:0] MINUTE_LAST =
    `HALF_CNT_W'(`MINUTE_HALF_SEC * `MS_PER_SEC - 1);

  logic [`PRESCALE_W-1:0] pre_reg, pre_next;
  logic [`HALF_CNT_W-1:0] fast_cnt_reg, fast_cnt_next;
  logic [`HALF_CNT_W-1:0] tenth_cnt_reg, tenth_cnt_next;
  logic [`HALF_CNT_W-1:0] second_cnt_reg, second_cnt_next;
  logic [`HALF_CNT_W-1:0] minute_cnt_reg, minute_cnt_next;
  logic [3:0] flags_reg, flags_next;
  logic tick_reg, tick_next;

  // Wraps at the half period; all share one tick so edges line up
  function automatic logic [`HALF_CNT_W-1:0] half_step(
    input logic [`HALF_CNT_W-1:0] cnt,
    input logic [`HALF_CNT_W-1:0] last,
    input logic tick
  );
    if (!tick)
      return cnt;
    return (cnt == last) ? '0 : cnt + `HALF_CNT_W'(1);
  endfunction

  always_comb
  begin
    tick_next = (pre_reg == PRE_LAST);
    pre_next = tick_next ? '0 : pre_reg + `PRESCALE_W'(1);
    fast_cnt_next = half_step(fast_cnt_reg, FAST_LAST, tick_reg); // R1 R16
    tenth_cnt_next = half_step(tenth_cnt_reg, TENTH_LAST, tick_reg); // R2 R16
    second_cnt_next = half_step(second_cnt_reg, SECOND_LAST, tick_reg); // R3 R16
    minute_cnt_next = half_step(minute_cnt_reg, MINUTE_LAST, tick_reg); // R4 R16
    flags_next = flags_reg;
    if (tick_reg)
    begin
      flags_next[0] = flags_reg[0] ^ (fast_cnt_reg == FAST_LAST); // R1
      flags_next[1] = flags_reg[1] ^ (tenth_cnt_reg == TENTH_LAST); // R2
      flags_next[2] = flags_reg[2] ^ (second_cnt_reg == SECOND_LAST); // R3
      flags_next[3] = flags_reg[3] ^ (minute_cnt_reg == MINUTE_LAST); // R4
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pre_reg <= '0;
      tick_reg <= 1'b0;
      fast_cnt_reg <= '0;
      tenth_cnt_reg <= '0;
      second_cnt_reg <= '0;
      minute_cnt_reg <= '0;
      flags_reg <= 4'h0;
    end
    else
    begin
      pre_reg <= pre_next;
      tick_reg <= tick_next;
      fast_cnt_reg <= fast_cnt_next;
      tenth_cnt_reg <= tenth_cnt_next;
      second_cnt_reg <= second_cnt_next;
      minute_cnt_reg <= minute_cnt_next;
      flags_reg <= flags_next;
    end
  end

  assign ms_tick = tick_reg;
  assign flag_10ms = flags_reg[0];
  assign flag_100ms = flags_reg[1];
  assign flag_1s = flags_reg[2];
  assign flag_1min = flags_reg[3];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_fast_toggle: assert property ( // R1
    (tick_reg && fast_cnt_reg == FAST_LAST) |=> (flag_10ms != $past(flag_10ms)))
    else $error("fast flag did not toggle at half period");
  chk_tenth_toggle: assert property ( // R2
    (tick_reg && tenth_cnt_reg != TENTH_LAST) |=> $stable(flag_100ms))
    else $error("tenth flag moved inside half period");
  chk_second_toggle: assert property ( // R3
    (tick_reg && second_cnt_reg == SECOND_LAST) |=> (flag_1s != $past(flag_1s)))
    else $error("second flag did not toggle at half period");
  chk_minute_hold: assert property ( // R4
    !tick_reg |=> $stable(flag_1min) && $stable(minute_cnt_reg))
    else $error("minute flag moved without a tick");
  chk_flags_aligned: assert property ( // R16
    $changed(flag_100ms) |-> $changed(flag_10ms))
    else $error("tenth and fast flag edges not aligned");

endmodule

//--- logic/special_flag_logic.sv
// Notes on behaviour
// R1 - Fast pulse flag: 10 ms period, 5 ms high, 5 ms low, forever.
// R2 - Tenth-second flag: 100 ms period, 50 ms low then 50 ms high.
// R3 - One-second flag: 1 s period, 500 ms high, 500 ms low.
// R4 - One-minute flag: 1 min period, 30 s high, 30 s low.
// R5 - Clock-halt request stops the real-time clock and allows preset of its time.
// R6 - Display-freeze request stops updating the shown clock reading.
// R7 - Clock-present flag is always high.
// R8 - Clock-fault flag goes high while the real-time clock reports an error.
// R9 - Retained clear zeroes timer, counter, data and special data values.
// R10 - Memory-keep set at RUN to STOP preserves image and data memory.
// R11 - Output-kill forces every external output contact off.
// R12 - Fixed-scan waits until scan_time_register has elapsed before next pass.
// R13 - Parameter-setting flag marks link parameter configuration.
// R14 - Clear and output-disable requests act only at end of scan.
// R15 - Volatile clear wipes on/off image of outputs, relays, timers, counters.
// R16 - All four pulse flags come from one shared time base.
`timescale 1ns/1ps
`include "flag_consts.svh"

module special_flag_logic
  import flag_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `NS_PER_MS / `CLK_PERIOD_NS
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic run_mode,
  input wire logic end_of_scan,
  input wire logic rtc_halt_req,
  input wire logic rtc_freeze_req,
  input wire logic rtc_fault_pin,
  input wire logic volatile_clear_req,
  input wire logic retained_clear_req,
  input wire logic memory_keep_req,
  input wire logic output_kill_req,
  input wire logic fixed_scan_req,
  input wire logic [`SCAN_TIME_W-1:0] scan_time_register,
  input wire logic param_set_req,
  output logic flag_10ms,
  output logic flag_100ms,
  output logic flag_1s,
  output logic flag_1min,
  output logic rtc_run,
  output logic rtc_preset_en,
  output logic rtc_display_update,
  output logic rtc_present,
  output logic rtc_fault_flag,
  output logic volatile_clear_pulse,
  output logic retained_clear_pulse,
  output logic stop_clear_pulse,
  output logic outputs_off,
  output logic link_param_mode,
  output logic scan_start
);

  logic ms_tick;

  // ****************************************
  // Pulse flags
  // ****************************************
  pulse_time_base #(
    .MS_CYCLES(MS_CYCLES)
  ) u_time_base (
    .core_clk(core_clk),
    .srst(srst),
    .ms_tick(ms_tick),
    .flag_10ms(flag_10ms),
    .flag_100ms(flag_100ms),
    .flag_1s(flag_1s),
    .flag_1min(flag_1min)
  );

  // ****************************************
  // Real-time clock control and status
  // ****************************************
  logic fault_s1_reg, fault_s2_reg, fault_s3_reg;
  logic fault_reg, fault_next;
  logic rtc_run_reg, rtc_run_next;
  logic preset_reg, preset_next;
  logic display_reg, display_next;
  logic param_reg, param_next;

  always_comb
  begin
    // Third stage only trusted once the last two stages agree
    fault_next = (fault_s2_reg == fault_s3_reg) ? fault_s3_reg : fault_reg; // R8
    rtc_run_next = !rtc_halt_req; // R5
    preset_next = rtc_halt_req; // R5
    display_next = !rtc_freeze_req; // R6
    param_next = param_set_req; // R13
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fault_s1_reg <= `RTC_FAULT_RST;
      fault_s2_reg <= `RTC_FAULT_RST;
      fault_s3_reg <= `RTC_FAULT_RST;
      fault_reg <= `RTC_FAULT_RST;
      rtc_run_reg <= 1'b1;
      preset_reg <= 1'b0;
      display_reg <= 1'b1;
      param_reg <= 1'b0;
    end
    else
    begin
      fault_s1_reg <= rtc_fault_pin;
      fault_s2_reg <= fault_s1_reg;
      fault_s3_reg <= fault_s2_reg;
      fault_reg <= fault_next;
      rtc_run_reg <= rtc_run_next;
      preset_reg <= preset_next;
      display_reg <= display_next;
      param_reg <= param_next;
    end
  end

  assign rtc_run = rtc_run_reg;
  assign rtc_preset_en = preset_reg;
  assign rtc_display_update = display_reg;
  assign rtc_fault_flag = fault_reg;
  assign link_param_mode = param_reg;
  assign rtc_present = 1'b1; // R7

  // ****************************************
  // End-of-scan actions and memory control
  // ****************************************
  logic vclear_reg, vclear_next;
  logic rclear_reg, rclear_next;
  logic stop_clear_reg, stop_clear_next;
  logic off_reg, off_next;
  logic run_prev_reg, run_prev_next;
  logic run_to_stop;

  always_comb
  begin
    run_prev_next = run_mode;
    run_to_stop = run_prev_reg && !run_mode;
    // Requests are sampled only at the scan boundary so a program that
    // toggles a flag mid-scan cannot tear its own outputs
    vclear_next = end_of_scan && volatile_clear_req; // R14 R15
    rclear_next = end_of_scan && retained_clear_req; // R14 R9
    off_next = end_of_scan ? output_kill_req : off_reg; // R14 R11
    // Without the keep flag, leaving RUN wipes image and data memory
    stop_clear_next = run_to_stop && !memory_keep_req; // R10
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      vclear_reg <= 1'b0;
      rclear_reg <= 1'b0;
      stop_clear_reg <= 1'b0;
      off_reg <= `OUTPUTS_OFF_RST;
      run_prev_reg <= 1'b0;
    end
    else
    begin
      vclear_reg <= vclear_next;
      rclear_reg <= rclear_next;
      stop_clear_reg <= stop_clear_next;
      off_reg <= off_next;
      run_prev_reg <= run_prev_next;
    end
  end

  assign volatile_clear_pulse = vclear_reg;
  assign retained_clear_pulse = rclear_reg;
  assign stop_clear_pulse = stop_clear_reg;
  assign outputs_off = off_reg;

  // ****************************************
  // Constant scan timing
  // ****************************************
  scan_state_type state_reg, state_next;
  logic [`SCAN_TIME_W-1:0] elapsed_reg, elapsed_next;
  logic start_reg, start_next;
  logic time_met;

  always_comb
  begin
    state_next = state_reg;
    start_next = 1'b0;
    time_met = (elapsed_reg >= scan_time_register);
    elapsed_next = elapsed_reg;
    // Saturates so a very long scan never wraps back under the target
    if (ms_tick && elapsed_reg != '1)
      elapsed_next = elapsed_reg + `SCAN_TIME_W'(1);
    case (state_reg)
      SCAN_BUSY:
      begin
        if (end_of_scan)
        begin
          if (fixed_scan_req && !time_met)
            state_next = SCAN_HOLD; // R12
          else
            start_next = 1'b1;
        end
      end
      SCAN_HOLD:
      begin
        if (time_met || !fixed_scan_req)
        begin
          start_next = 1'b1; // R12
          state_next = SCAN_BUSY;
        end
      end
      default:
      begin
        state_next = SCAN_BUSY;
      end
    endcase
    if (start_next)
      elapsed_next = '0;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_reg <= SCAN_BUSY;
      elapsed_reg <= '0;
      start_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      elapsed_reg <= elapsed_next;
      start_reg <= start_next;
    end
  end

  assign scan_start = start_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_halt_stops_clock: assert property ( // R5
    rtc_halt_req |=> !rtc_run && rtc_preset_en)
    else $error("clock kept running while halted");
  chk_freeze_display: assert property ( // R6
    rtc_freeze_req |=> !rtc_display_update)
    else $error("display updated while frozen");
  chk_present_high: assert property ( // R7
    rtc_present)
    else $error("clock present flag dropped");
  chk_fault_follows: assert property ( // R8
    (fault_s2_reg && fault_s3_reg) |=> rtc_fault_flag)
    else $error("fault not raised after stable input");
  chk_retained_clear: assert property ( // R9
    retained_clear_pulse |-> $past(end_of_scan) && $past(retained_clear_req))
    else $error("retained clear outside end of scan");
  chk_keep_on_stop: assert property ( // R10
    (run_prev_reg && !run_mode && memory_keep_req) |=> !stop_clear_pulse)
    else $error("memory cleared although keep was set");
  chk_kill_apply: assert property ( // R11
    (end_of_scan && output_kill_req) |=> outputs_off)
    else $error("outputs not disabled at end of scan");
  chk_kill_end_only: assert property ( // R14
    !end_of_scan |=> $stable(outputs_off))
    else $error("output disable changed mid scan");
  chk_fixed_wait: assert property ( // R12
    (state_reg == SCAN_HOLD && fixed_scan_req && !time_met) |=> !scan_start)
    else $error("scan started before fixed time elapsed");
  chk_volatile_clear: assert property ( // R15
    (end_of_scan && volatile_clear_req) |=> volatile_clear_pulse)
    else $error("volatile clear not issued");
  chk_volatile_source: assert property ( // R14
    volatile_clear_pulse |-> $past(end_of_scan) && $past(volatile_clear_req))
    else $error("volatile clear outside end of scan");
  chk_param_flag: assert property ( // R13
    param_set_req |=> link_param_mode)
    else $error("parameter flag not shown");

endmodule

//--- bench/special_flag_logic_bench.sv
`timescale 1ns/1ps
`include "flag_consts.svh"

module special_flag_logic_bench;
  import flag_pkg::*;
  // ****************************************
  // Ports and clock
  // ****************************************
  // Short ms keeps the run small
  localparam int unsigned MS = 10;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic run_mode = 1'b1;
  logic end_of_scan = 1'b0;
  logic rtc_halt_req = 1'b0;
  logic rtc_freeze_req = 1'b0;
  logic rtc_fault_pin = 1'b0;
  logic volatile_clear_req = 1'b0;
  logic retained_clear_req = 1'b0;
  logic memory_keep_req = 1'b0;
  logic output_kill_req = 1'b0;
  logic fixed_scan_req = 1'b0;
  logic [`SCAN_TIME_W-1:0] scan_time_register = 16'h0000;
  logic param_set_req = 1'b0;
  logic flag_10ms, flag_100ms, flag_1s, flag_1min;
  logic rtc_run, rtc_preset_en, rtc_display_update, rtc_present, rtc_fault_flag;
  logic volatile_clear_pulse, retained_clear_pulse, stop_clear_pulse;
  logic outputs_off, link_param_mode, scan_start;
  logic p10 = 1'b0;
  logic p100 = 1'b0;
  logic p1s = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  int hits [9];
  int n;
  int half_ms [3] = '{`FAST_HALF_MS, `TENTH_HALF_MS, `SECOND_HALF_MS};

  always #5 core_clk = ~core_clk;

  special_flag_logic #(.MS_CYCLES(MS)) dut_u (
    .core_clk(core_clk), .srst(srst), .run_mode(run_mode), .end_of_scan(end_of_scan),
    .rtc_halt_req(rtc_halt_req), .rtc_freeze_req(rtc_freeze_req),
    .rtc_fault_pin(rtc_fault_pin), .volatile_clear_req(volatile_clear_req),
    .retained_clear_req(retained_clear_req), .memory_keep_req(memory_keep_req),
    .output_kill_req(output_kill_req), .fixed_scan_req(fixed_scan_req),
    .scan_time_register(scan_time_register), .param_set_req(param_set_req),
    .flag_10ms(flag_10ms), .flag_100ms(flag_100ms), .flag_1s(flag_1s),
    .flag_1min(flag_1min), .rtc_run(rtc_run), .rtc_preset_en(rtc_preset_en),
    .rtc_display_update(rtc_display_update), .rtc_present(rtc_present),
    .rtc_fault_flag(rtc_fault_flag), .volatile_clear_pulse(volatile_clear_pulse),
    .retained_clear_pulse(retained_clear_pulse), .stop_clear_pulse(stop_clear_pulse),
    .outputs_off(outputs_off), .link_param_mode(link_param_mode),
    .scan_start(scan_start)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic pick(input int i);
    case (i)
      0: pick = flag_10ms;
      1: pick = flag_100ms;
      2: pick = flag_1s;
      3: pick = rtc_fault_flag;
      4: pick = volatile_clear_pulse;
      5: pick = retained_clear_pulse;
      6: pick = stop_clear_pulse;
      7: pick = scan_start;
      8: pick = outputs_off;
      default: pick = 1'bx;
    endcase
  endfunction

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_num(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp)
    begin
      bad_count++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Bounded wait, counted in cycles from the current falling edge
  task automatic wait_for(input int i, input logic v, input int bound, output int c);
    c = 0;
    while (pick(i) !== v && c < bound)
    begin
      @(negedge core_clk);
      c++;
    end
    if (pick(i) !== v)
    begin
      bad_count++;
      $display("unexpected timeout on output %0d", i);
      close_out();
    end
  endtask

  // Counts high cycles of every watched output over a window
  task automatic window(input int len);
    foreach (hits[j])
      hits[j] = 0;
    for (int k = 0; k < len; k++)
    begin
      foreach (hits[j])
        hits[j] += int'(pick(j) === 1'b1);
      @(negedge core_clk);
    end
  endtask

  task automatic end_scan;
    end_of_scan = 1'b1;
    @(negedge core_clk);
    end_of_scan = 1'b0;
  endtask

  // Slow flags may only move together with the fast one
  always @(negedge core_clk)
  begin
    if (!srst && (flag_100ms !== p100 || flag_1s !== p1s))
      check_bit("flag_10ms edge", ~p10, flag_10ms);
    p10 <= flag_10ms;
    p100 <= flag_100ms;
    p1s <= flag_1s;
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (10) @(negedge core_clk);
    srst = 1'b0;
    check_bit("rtc_present", 1'b1, rtc_present);
    check_bit("rtc_run", 1'b1, rtc_run);
    check_bit("outputs_off", 1'b0, outputs_off);
    rtc_halt_req = 1'b1;
    rtc_freeze_req = 1'b1;
    param_set_req = 1'b1;
    repeat (2) @(negedge core_clk);
    check_bit("rtc_run", 1'b0, rtc_run);
    check_bit("rtc_preset_en", 1'b1, rtc_preset_en);
    check_bit("rtc_display_update", 1'b0, rtc_display_update);
    check_bit("link_param_mode", 1'b1, link_param_mode);
    rtc_halt_req = 1'b0;
    rtc_freeze_req = 1'b0;
    param_set_req = 1'b0;
    repeat (2) @(negedge core_clk);
    check_bit("rtc_run", 1'b1, rtc_run);
    check_bit("rtc_preset_en", 1'b0, rtc_preset_en);
    check_bit("rtc_display_update", 1'b1, rtc_display_update);
    check_bit("link_param_mode", 1'b0, link_param_mode);
    rtc_fault_pin = 1'b1;
    wait_for(3, 1'b1, 8, n);
    check_num("fault rise delay", 4, n);
    rtc_fault_pin = 1'b0;
    wait_for(3, 1'b0, 8, n);
    check_num("fault fall delay", 4, n);
    // Requests between scan ends must wait for the next one
    output_kill_req = 1'b1;
    retained_clear_req = 1'b1;
    volatile_clear_req = 1'b1;
    window(6);
    check_num("early outputs_off", 0, hits[8] + hits[5] + hits[4]);
    end_scan();
    window(4);
    check_num("outputs_off cycles", 4, hits[8]);
    check_num("retained pulses", 1, hits[5]);
    check_num("volatile pulses", 1, hits[4]);
    check_num("free scan starts", 1, hits[7]);
    output_kill_req = 1'b0;
    retained_clear_req = 1'b0;
    volatile_clear_req = 1'b0;
    window(3);
    check_num("held outputs_off", 3, hits[8]);
    end_scan();
    window(3);
    check_num("released outputs_off", 0, hits[8]);
    check_num("no retained pulse", 0, hits[5]);
    run_mode = 1'b0;
    window(4);
    check_num("stop clear pulses", 1, hits[6]);
    run_mode = 1'b1;
    window(2);
    memory_keep_req = 1'b1;
    run_mode = 1'b0;
    window(4);
    check_num("kept stop pulses", 0, hits[6]);
    memory_keep_req = 1'b0;
    run_mode = 1'b1;
    // Long idle means the target is already met
    scan_time_register = 16'h0003;
    fixed_scan_req = 1'b1;
    repeat (4 * MS) @(negedge core_clk);
    end_scan();
    check_bit("scan_start late scan", 1'b1, scan_start);
    @(negedge core_clk);
    end_scan();
    wait_for(7, 1'b1, 60, n);
    check_bit("fixed scan wait", 1'b1, n >= 2 * MS && n <= 3 * MS);
    fixed_scan_req = 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      // Start from a low phase so the high time is measured whole
      wait_for(k, 1'b0, half_ms[k] * MS + 20, n);
      wait_for(k, 1'b1, 2 * half_ms[k] * MS + 20, n);
      wait_for(k, 1'b0, half_ms[k] * MS + 20, n);
      check_num("pulse high cycles", half_ms[k] * MS, n);
      wait_for(k, 1'b1, half_ms[k] * MS + 20, n);
      check_num("pulse low cycles", half_ms[k] * MS, n);
    end
    // Minute half period is far longer than this run
    check_bit("flag_1min", 1'b0, flag_1min);
    check_bit("rtc_present", 1'b1, rtc_present);
    close_out();
  end
endmodule
